//--- clk_status_pkg.sv
package clk_status_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] ADDR_CHAN_DIV_LOW      = 12'h197;
	localparam logic [11:0] ADDR_CHAN_DIV_HIGH     = 12'h198;
	localparam logic [11:0] ADDR_CLEANUP_CTRL      = 12'h1BA;
	localparam logic [11:0] ADDR_CLEANUP_CHAN_CTRL = 12'h1BB;
	localparam logic [11:0] ADDR_LOCK_STATUS       = 12'h22C;
	localparam logic [11:0] ADDR_HOLDOVER_STATUS   = 12'h22D;

	// ==========================================================
	// Field positions
	localparam int PHASE_LSB     = 2;
	localparam int DIV_HIGH_MSB  = 1;
	localparam int WEAK_DRIVE_BIT = 4;
	localparam int PWRDN_BIT     = 7;
	localparam int CH1_VCXO_BIT  = 1;
	localparam int CH0_VCXO_BIT  = 0;
	localparam int HOLDOVER_BIT  = 3;
	localparam int REF_SEL_BIT   = 2;
	localparam int VCO_CAL_BIT   = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CHAN_DIV_LOW      = 8'h00;
	localparam logic [7:0] RST_CHAN_DIV_HIGH     = 8'h00;
	localparam logic [7:0] RST_CLEANUP_CTRL      = 8'h01;
	localparam logic [7:0] RST_CLEANUP_CHAN_CTRL = 8'h00;

	// ==========================================================
	// Cleanup output divider codes
	localparam logic [3:0] CODE_DIV1  = 4'h0;
	localparam logic [3:0] CODE_DIV2  = 4'h1;
	localparam logic [3:0] CODE_DIV4  = 4'h2;
	localparam logic [3:0] CODE_DIV8  = 4'h4;
	localparam logic [3:0] CODE_DIV16 = 4'h8;

	// ==========================================================
	// Status carried from the analog core
	typedef struct packed {
		logic vco_synthesis_loop_ref_ok;
		logic cleanup_loop_fb_ok;
		logic vcxo_ok;
		logic test_ref_ok;
		logic reference_input_b_ok;
		logic reference_input_a_ok;
		logic vco_synthesis_loop_locked;
		logic cleanup_loop_locked;
		logic holdover;
		logic ref_b_selected;
		logic auto_ref_mode;
		logic vco_cal_busy;
	} core_status_t;
endpackage

//--- chan_phase_divider.sv
`timescale 1ns/1ps
module chan_phase_divider #(
	parameter int DIV_W   = 10,
	parameter int PHASE_W = 6
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_half_tick,
	input  wire logic               i_sync,
	input  wire logic [DIV_W-1:0]   i_div,
	input  wire logic [PHASE_W-1:0] i_phase,
	output logic                    o_clk
);
	initial
	begin
		if (DIV_W < 1 || PHASE_W < 1)
			$error("chan_phase_divider: widths must be positive");
	end

	typedef enum logic {ST_DELAY, ST_RUN} div_state_t;

	div_state_t         state_reg, state_next;
	logic [DIV_W:0]     cnt_reg, cnt_next;
	logic [PHASE_W-1:0] dly_reg, dly_next;
	logic               out_reg, out_next;
	logic [DIV_W:0]     half_len;

	// ==========================================================
	// Next state: counts half periods of the divider input
	always_comb
	begin
		half_len   = {1'b0, i_div} + {{DIV_W{1'b0}}, 1'b1};
		state_next = state_reg;
		cnt_next   = cnt_reg;
		dly_next   = dly_reg;
		out_next   = out_reg;
		if (i_sync)
		begin
			// Each phase step is one half period of the input
			state_next = ST_DELAY;
			dly_next   = i_phase;
			cnt_next   = '0;
			out_next   = 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_DELAY:
				begin
					if (dly_reg == '0)
					begin
						state_next = ST_RUN;
						out_next   = 1'b1;
					end
					else if (i_half_tick)
						dly_next = dly_reg - 1'b1;
				end
				ST_RUN:
				begin
					if (i_half_tick)
					begin
						// Full period is 2*(N+1) half ticks, 50% duty
						if (cnt_reg == {half_len[DIV_W-1:0], 1'b0} - 1'b1)
							cnt_next = '0;
						else
							cnt_next = cnt_reg + 1'b1;
						out_next = (cnt_next < half_len);
					end
				end
			endcase
		end
	end

	// ==========================================================
	// State registers
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= ST_RUN;
			cnt_reg   <= '0;
			dly_reg   <= '0;
			out_reg   <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			dly_reg   <= dly_next;
			out_reg   <= out_next;
		end
	end

	assign o_clk = out_reg;
endmodule

//--- clock_channel_ctrl_status_regs.sv
`timescale 1ns/1ps
module clock_channel_ctrl_status_regs (
	input  wire logic                        I_CLK_SYS,
	input  wire logic                        I_SYS_RST,
	input  wire logic                        I_REG_WR,
	input  wire logic                        I_REG_RD,
	input  wire logic [11:0]                 I_REG_ADDR,
	input  wire logic [7:0]                  I_REG_WDATA,
	input  wire clk_status_pkg::core_status_t I_CORE_STATUS,
	input  wire logic                        I_SYNC,
	input  wire logic                        I_VCO_DIV_HALF_TICK,
	input  wire logic                        I_VCXO_HALF_TICK,
	output logic [7:0]                       O_REG_RDATA,
	output logic                             O_REG_RVALID,
	output logic [1:0]                       O_CHAN_CLK,
	output logic                             O_CLEANUP_OUT,
	output logic                             O_CLEANUP_WEAK_DRIVE,
	output logic                             O_CLEANUP_PWRDN
);
	import clk_status_pkg::*;

	logic [7:0]   div_low_reg, div_low_next;
	logic [7:0]   div_high_reg, div_high_next;
	logic [7:0]   cu_ctrl_reg, cu_ctrl_next;
	logic [7:0]   cu_chan_reg, cu_chan_next;
	logic [7:0]   rdata_reg, rdata_next;
	logic         rvalid_reg;
	core_status_t stat_meta_reg, stat_reg;
	logic         sync_meta_reg, sync_reg;
	logic [4:0]   cu_cnt_reg, cu_cnt_next;
	logic         cu_out_reg, cu_out_next;
	logic         weak_reg, pwrdn_reg;
	logic [1:0]   ch_tick;
	logic [1:0]   ch_clk;
	logic [9:0]   div_val;

	// ==========================================================
	// Map a divider code to the counter bit to use
	function automatic logic [2:0] cleanup_tap(input logic [3:0] code);
		unique case (code)
			CODE_DIV1:  cleanup_tap = 3'h0;
			CODE_DIV2:  cleanup_tap = 3'h1;
			CODE_DIV4:  cleanup_tap = 3'h2;
			CODE_DIV8:  cleanup_tap = 3'h3;
			CODE_DIV16: cleanup_tap = 3'h4;
			// Forbidden codes fall back to the default ratio
			default:    cleanup_tap = 3'h1;
		endcase
	endfunction

	// ==========================================================
	// Status and sync pins cross from the analog core: two flops
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			stat_meta_reg <= '0;
			stat_reg      <= '0;
			sync_meta_reg <= 1'b0;
			sync_reg      <= 1'b0;
		end
		else
		begin
			stat_meta_reg <= I_CORE_STATUS;
			stat_reg      <= stat_meta_reg;
			sync_meta_reg <= I_SYNC;
			sync_reg      <= sync_meta_reg;
		end
	end

	// ==========================================================
	// Register writes and registered readback
	always_comb
	begin
		div_low_next  = div_low_reg;
		div_high_next = div_high_reg;
		cu_ctrl_next  = cu_ctrl_reg;
		cu_chan_next  = cu_chan_reg;
		rdata_next    = rdata_reg;
		if (I_REG_WR)
		begin
			// Readback addresses are absent here, so writes drop
			unique case (I_REG_ADDR)
				ADDR_CHAN_DIV_LOW:      div_low_next  = I_REG_WDATA;
				ADDR_CHAN_DIV_HIGH:     div_high_next = I_REG_WDATA;
				ADDR_CLEANUP_CTRL:      cu_ctrl_next  =
					{3'h0, I_REG_WDATA[4:0]};
				ADDR_CLEANUP_CHAN_CTRL: cu_chan_next  =
					{I_REG_WDATA[7], 5'h00, I_REG_WDATA[1:0]};
				default: ;
			endcase
		end
		if (I_REG_RD)
		begin
			unique case (I_REG_ADDR)
				ADDR_CHAN_DIV_LOW:      rdata_next = div_low_reg;
				ADDR_CHAN_DIV_HIGH:     rdata_next = div_high_reg;
				ADDR_CLEANUP_CTRL:      rdata_next = cu_ctrl_reg;
				ADDR_CLEANUP_CHAN_CTRL: rdata_next = cu_chan_reg;
				ADDR_LOCK_STATUS:
					rdata_next = {stat_reg.vco_synthesis_loop_ref_ok,
						stat_reg.cleanup_loop_fb_ok,
						stat_reg.vcxo_ok,
						stat_reg.test_ref_ok,
						stat_reg.reference_input_b_ok,
						stat_reg.reference_input_a_ok,
						stat_reg.vco_synthesis_loop_locked,
						stat_reg.cleanup_loop_locked};
				ADDR_HOLDOVER_STATUS:
				begin
					rdata_next = 8'h00;
					rdata_next[HOLDOVER_BIT] = stat_reg.holdover;
					// Meaningless in manual mode, so it reads zero there
					rdata_next[REF_SEL_BIT] = stat_reg.auto_ref_mode
						& stat_reg.ref_b_selected;
					rdata_next[VCO_CAL_BIT] = stat_reg.vco_cal_busy;
				end
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Register bank flops
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			div_low_reg  <= RST_CHAN_DIV_LOW;
			div_high_reg <= RST_CHAN_DIV_HIGH;
			cu_ctrl_reg  <= RST_CLEANUP_CTRL;
			cu_chan_reg  <= RST_CLEANUP_CHAN_CTRL;
			rdata_reg    <= 8'h00;
			rvalid_reg   <= 1'b0;
		end
		else
		begin
			div_low_reg  <= div_low_next;
			div_high_reg <= div_high_next;
			cu_ctrl_reg  <= cu_ctrl_next;
			cu_chan_reg  <= cu_chan_next;
			rdata_reg    <= rdata_next;
			rvalid_reg   <= I_REG_RD;
		end
	end

	// ==========================================================
	// Channel dividers with per-channel input routing
	assign div_val = {div_high_reg[DIV_HIGH_MSB:0], div_low_reg};
	assign ch_tick[0] = cu_chan_reg[CH0_VCXO_BIT] ?
		I_VCXO_HALF_TICK : I_VCO_DIV_HALF_TICK;
	assign ch_tick[1] = cu_chan_reg[CH1_VCXO_BIT] ?
		I_VCXO_HALF_TICK : I_VCO_DIV_HALF_TICK;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			chan_phase_divider #(
				.DIV_W   (10),
				.PHASE_W (6)
			) u_div (
				.i_clk       (I_CLK_SYS),
				.i_rst       (I_SYS_RST),
				.i_half_tick (ch_tick[ch]),
				.i_sync      (sync_reg),
				.i_div       (div_val),
				.i_phase     (div_high_reg[7:PHASE_LSB]),
				.o_clk       (ch_clk[ch])
			);
		end
	endgenerate

	// ==========================================================
	// Cleanup loop buffered output: binary divider on VCXO ticks
	always_comb
	begin
		cu_cnt_next = cu_cnt_reg;
		if (I_VCXO_HALF_TICK)
			cu_cnt_next = cu_cnt_reg + 1'b1;
		// Powered-down driver is held low to avoid glitches on restart
		if (cu_chan_reg[PWRDN_BIT])
			cu_out_next = 1'b0;
		else
			cu_out_next = cu_cnt_next[cleanup_tap(cu_ctrl_reg[3:0])];
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			cu_cnt_reg <= 5'h00;
			cu_out_reg <= 1'b0;
			weak_reg   <= 1'b0;
			pwrdn_reg  <= 1'b0;
		end
		else
		begin
			cu_cnt_reg <= cu_cnt_next;
			cu_out_reg <= cu_out_next;
			weak_reg   <= cu_ctrl_reg[WEAK_DRIVE_BIT];
			pwrdn_reg  <= cu_chan_reg[PWRDN_BIT];
		end
	end

	assign O_REG_RDATA          = rdata_reg;
	assign O_REG_RVALID         = rvalid_reg;
	assign O_CHAN_CLK           = ch_clk;
	assign O_CLEANUP_OUT        = cu_out_reg;
	assign O_CLEANUP_WEAK_DRIVE = weak_reg;
	assign O_CLEANUP_PWRDN      = pwrdn_reg;
endmodule

//--- clock_channel_ctrl_status_regs_sva.sv
`timescale 1ns/1ps
module clock_channel_ctrl_status_regs_sva
	import clk_status_pkg::*;
(
	input wire logic                         I_CLK_SYS,
	input wire logic                         I_SYS_RST,
	input wire logic                         I_REG_WR,
	input wire logic                         I_REG_RD,
	input wire logic [11:0]                  I_REG_ADDR,
	input wire logic [7:0]                   I_REG_WDATA,
	input wire clk_status_pkg::core_status_t I_CORE_STATUS,
	input wire logic                         I_SYNC,
	input wire logic [7:0]                   O_REG_RDATA,
	input wire logic                         O_REG_RVALID,
	input wire logic                         O_CLEANUP_OUT,
	input wire logic [1:0]                   O_CHAN_CLK,
	input wire logic                         O_CLEANUP_WEAK_DRIVE,
	input wire logic                         O_CLEANUP_PWRDN
);
	// ==========
	// Status must sit still across the synchroniser before a read is judged
	core_status_t st_reg;
	core_status_t st_next;
	logic [1:0]   sc_reg;
	logic [1:0]   sc_next;
	logic [7:0]   hold_map;
	assign hold_map = {4'h0, I_CORE_STATUS.holdover,
		I_CORE_STATUS.auto_ref_mode & I_CORE_STATUS.ref_b_selected,
		1'b0, I_CORE_STATUS.vco_cal_busy};
	always_comb
	begin
		st_next = I_CORE_STATUS;
		sc_next = (I_CORE_STATUS != st_reg) ? 2'h0
			: sc_reg + {1'b0, sc_reg != 2'h3};
	end
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
		if (I_SYS_RST)
		begin
			st_reg <= '0;
			sc_reg <= 2'h0;
		end
		else
		begin
			st_reg <= st_next;
			sc_reg <= sc_next;
		end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	// ==========
	// Bus answers, readback maps, control copies and outputs held low
	a_read_answer:
		assert property (I_REG_RD |=> O_REG_RVALID) else $error("no answer");
	a_rdata_holds:
		assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA))
		else $error("read data moved");
	a_lock_map:
		assert property (I_REG_RD && I_REG_ADDR == ADDR_LOCK_STATUS
			&& sc_reg == 2'h3 && $stable(I_CORE_STATUS)
			|=> O_REG_RDATA == $past(I_CORE_STATUS[11:4]))
		else $error("lock map");
	a_hold_map:
		assert property (I_REG_RD && I_REG_ADDR == ADDR_HOLDOVER_STATUS
			&& sc_reg == 2'h3 && $stable(I_CORE_STATUS)
			|=> O_REG_RDATA == $past(hold_map)) else $error("holdover map");
	a_unmapped_zero:
		assert property (I_REG_RD && I_REG_ADDR == 12'h100
			|=> O_REG_RDATA == 8'h00)
		else $error("unmapped read");
	a_weak_copy:
		assert property (I_REG_WR && I_REG_ADDR == ADDR_CLEANUP_CTRL
			##1 !I_REG_WR
			|=> O_CLEANUP_WEAK_DRIVE == $past(I_REG_WDATA[4], 2))
		else $error("weak");
	a_pwrdn_copy:
		assert property (I_REG_WR && I_REG_ADDR == ADDR_CLEANUP_CHAN_CTRL
			##1 !I_REG_WR
			|=> O_CLEANUP_PWRDN == $past(I_REG_WDATA[7], 2))
		else $error("pwrdn");
	a_pwrdn_quiet:
		assert property (O_CLEANUP_PWRDN [*2] |-> !O_CLEANUP_OUT) else $error("out");
	a_sync_holds_low:
		assert property (I_SYNC [*5] |-> O_CHAN_CLK == 2'h0) else $error("sync");
endmodule
bind clock_channel_ctrl_status_regs clock_channel_ctrl_status_regs_sva u_sva (.*);

//--- clock_channel_ctrl_status_regs_test.sv
`timescale 1ns/1ps
module clock_channel_ctrl_status_regs_test;
	import clk_status_pkg::*;
	logic         clk, rst, wr, rd, sy, vt, xt, co, wk, pd, rv;
	logic [11:0]  ad;
	logic [7:0]   wd, q;
	logic [1:0]   cc;
	core_status_t st;
	logic [31:0]  seed = 32'h1E;
	logic [31:0]  r;
	int           num_errors, check_count, p0, p1, n, ph, i;
	clock_channel_ctrl_status_regs u_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst),
		.I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(ad), .I_REG_WDATA(wd),
		.I_CORE_STATUS(st), .I_SYNC(sy), .I_VCO_DIV_HALF_TICK(vt),
		.I_VCXO_HALF_TICK(xt), .O_REG_RDATA(q), .O_REG_RVALID(rv),
		.O_CHAN_CLK(cc), .O_CLEANUP_OUT(co), .O_CLEANUP_WEAK_DRIVE(wk),
		.O_CLEANUP_PWRDN(pd));
	// ==========
	// Clock, and a VCXO half tick on every other cycle to tell routes apart
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) xt <= ~xt;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] e_hold(input core_status_t s);
		return {4'h0, s.holdover, s.auto_ref_mode & s.ref_b_selected, 1'b0,
			s.vco_cal_busy};
	endfunction
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chn(input string nm, input int e, input int g);
		check_count++;
		if (g != e)
		begin
			num_errors++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask
	// ==========
	// Strobe pulses of one cycle; the read answer is looked at mid-cycle
	task automatic wrt(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		ad <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rvalid", 8'h01, {7'h0, rv});
		chk("rdata", e, q);
	endtask
	// Cycles between the 2nd and 3rd rising edge; the first may be transitional
	task automatic per(input int w, output int p);
		int t, k;
		logic v, o;
		t = 0;
		k = 0;
		o = 1'b1;
		p = 0;
		// A shrunk divider may first run its counter round to wrap
		while (k < 3 && t < 5000)
		begin
			@(posedge clk);
			v = (w == 2) ? co : cc[w];
			t++;
			if (v === 1'b1 && o === 1'b0)
			begin
				if (k == 2)
					p = t;
				k++;
				t = 0;
			end
			o = v;
		end
		if (k < 3)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic dly(output int d);
		sy <= 1'b1;
		repeat (6) @(posedge clk);
		sy <= 1'b0;
		d = 0;
		while (cc[0] !== 1'b1 && d < 300)
		begin
			@(posedge clk);
			d++;
		end
		if (d >= 300)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	// ==========
	// Reset, register map, status readback, dividers and phase
	initial
	begin
		{rst, wr, rd, sy, vt, xt, ad, wd, st} = {4'h8, 2'h2, 32'h0};
		num_errors = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(ADDR_CHAN_DIV_HIGH, RST_CHAN_DIV_HIGH);
		rc(ADDR_CLEANUP_CTRL, RST_CLEANUP_CTRL);
		rc(ADDR_CLEANUP_CHAN_CTRL, RST_CLEANUP_CHAN_CTRL);
		wrt(ADDR_CLEANUP_CTRL, 8'hF1);
		rc(ADDR_CLEANUP_CTRL, 8'h11);
		chk("weak", 8'h01, {7'h0, wk});
		wrt(ADDR_CLEANUP_CHAN_CTRL, 8'hFE);
		rc(ADDR_CLEANUP_CHAN_CTRL, 8'h82);
		chk("pwrdn", 8'h01, {7'h0, pd});
		chk("pwrdn out", 8'h00, {7'h0, co});
		wrt(ADDR_LOCK_STATUS, 8'hFF);
		wrt(ADDR_HOLDOVER_STATUS, 8'hFF);
		rc(ADDR_LOCK_STATUS, 8'h00);
		rc(12'h100, 8'h00);
		for (i = 0; i < 10; i++)
		begin
			r = rnd();
			@(posedge clk);
			st <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h004 : r[11:0];
			repeat (4) @(posedge clk);
			rc(ADDR_LOCK_STATUS, st[11:4]);
			rc(ADDR_HOLDOVER_STATUS, e_hold(st));
		end
		wrt(ADDR_CLEANUP_CHAN_CTRL, 8'h02);
		for (i = 0; i < 3; i++)
		begin
			r = rnd();
			n = (i == 0) ? 0 : (i == 1) ? 256 + r % 3 : 1 + r % 7;
			wrt(ADDR_CHAN_DIV_LOW, n[7:0]);
			wrt(ADDR_CHAN_DIV_HIGH, {6'h0, n[9:8]});
			rc(ADDR_CHAN_DIV_HIGH, {6'h0, n[9:8]});
			per(0, p0);
			chn("ch0 period", 2 * (n + 1), p0);
			per(1, p1);
			chn("ch1 period", 4 * (n + 1), p1);
		end
		for (i = 0; i < 5; i++)
		begin
			wrt(ADDR_CLEANUP_CTRL, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
			per(2, p0);
			chk("weak", 8'h00, {7'h0, wk});
			chn("cleanup period", 4 << i, p0);
		end
		wrt(ADDR_CHAN_DIV_LOW, 8'h03);
		for (i = 0; i < 4; i++)
		begin
			r = rnd();
			ph = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 63 : r % 64;
			wrt(ADDR_CHAN_DIV_HIGH, {ph[5:0], 2'h0});
			dly(p1);
			if (i == 0)
				p0 = p1;
			else
				chn("phase delay", ph, p1 - p0);
		end
		print_verdict();
	end
endmodule
